// >>> hw/adc_port_defines.vh
`ifndef ADC_PORT_DEFINES_VH
`define ADC_PORT_DEFINES_VH

// word lengths on the serial line, and bit counter width
`define ADC_WORD_BITS 24
`define ADC_SHORT_BITS 16
`define ADC_CNT_BITS 5

// control register fields
`define ADC_CTRL_SHORT_BIT 0
`define ADC_CTRL_CALSEL_BIT 1

// reset values
`define ADC_CTRL_RESET 24'h000000
`define ADC_CAL_RESET 24'h000000
`define ADC_OUT_RESET 24'h000000

// pin synchroniser: {sclk, rfs_n, tfs_n, sel, sdi} idle levels
`define ADC_PIN_COUNT 5
`define ADC_PIN_IDLE 5'h0E
`define ADC_PIN_SCLK 4
`define ADC_PIN_RFS 3
`define ADC_PIN_TFS 2
`define ADC_PIN_SEL 1
`define ADC_PIN_SDI 0

// fifo
`define ADC_FIFO_DEPTH 8

`endif

// >>> hw/sample_fifo.v
`timescale 1ns/1ps
module sample_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire core_clk, // system clock
  input wire resetn, // async reset, active low
  input wire [WIDTH-1:0] in_data, // write data
  input wire in_valid, // write request
  output reg in_ready, // not full
  output wire [WIDTH-1:0] out_data, // head word
  output reg out_valid, // not empty
  input wire out_ready // pop request
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] count_q;
  wire push;
  wire pop;
  wire [AW:0] count_d;

  assign push = in_valid & in_ready;
  assign pop = out_ready & out_valid;
  assign count_d = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign out_data = mem[rd_ptr_q];

  function [AW-1:0] bump;
    input [AW-1:0] p;
    begin
      if (p == DEPTH - 1)
        bump = {AW{1'b0}};
      else
        bump = p + {{(AW-1){1'b0}}, 1'b1};
    end
  endfunction

  always @(posedge core_clk) begin
    if (push)
      mem[wr_ptr_q] <= in_data;
  end

  // flags registered from next count so ports come from flops
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push)
        wr_ptr_q <= bump(wr_ptr_q);
      if (pop)
        rd_ptr_q <= bump(rd_ptr_q);
      count_q <= count_d;
      in_ready <= (count_d != DEPTH);
      out_valid <= (count_d != {(AW+1){1'b0}});
    end
  end
endmodule

// >>> hw/adc_serial_port.v
`timescale 1ns/1ps
`include "adc_port_defines.vh"
module adc_serial_port #(
  parameter FIFO_DEPTH = `ADC_FIFO_DEPTH
) (
  input wire core_clk, // 40 MHz system clock
  input wire resetn, // async reset, active low
  input wire serial_clk, // host serial clock pin
  input wire receive_frame_n, // read frame, active low
  input wire transmit_frame_n, // write frame, active low
  input wire register_select, // high: output/cal, low: control
  input wire serial_io_line_in, // data pin, input side
  output reg serial_io_line_out, // data pin, output side
  output reg serial_io_line_oe, // data pin drive enable
  output reg word_available_n, // new output word, active low
  input wire [`ADC_WORD_BITS-1:0] sample_data, // converter result
  input wire sample_valid, // result offered
  output wire sample_ready, // fifo has room
  output reg [`ADC_WORD_BITS-1:0] ctrl_q, // control register
  output reg [`ADC_WORD_BITS-1:0] cal_q, // calibration register
  output reg write_done // one-cycle pulse per committed write
);
  localparam W = `ADC_WORD_BITS;
  localparam CW = `ADC_CNT_BITS;
  localparam NP = `ADC_PIN_COUNT;
  localparam [1:0] KIND_OUT = 2'h0;
  localparam [1:0] KIND_CTRL = 2'h1;
  localparam [1:0] KIND_CAL = 2'h2;
  localparam integer LONG_I = `ADC_WORD_BITS - 1;
  localparam integer SHORT_I = `ADC_SHORT_BITS - 1;
  localparam [CW-1:0] LAST_LONG = LONG_I[CW-1:0];
  localparam [CW-1:0] LAST_SHORT = SHORT_I[CW-1:0];
  localparam [CW-1:0] CNT_ONE = 5'h01;

  reg [NP-1:0] s1_q;
  reg [NP-1:0] s2_q;
  reg [NP-1:0] s3_q;
  reg [NP-1:0] pin_q;
  reg [NP-1:0] prev_q;

  reg rd_act_q;
  reg rd_act_d;
  reg [1:0] rd_kind_q;
  reg [1:0] rd_kind_d;
  reg [CW-1:0] rd_cnt_q;
  reg [CW-1:0] rd_cnt_d;
  reg [W-1:0] rd_shift_q;
  reg [W-1:0] rd_shift_d;
  reg word_available_n_n_d;

  reg [CW-1:0] wr_cnt_q;
  reg [W-1:0] wr_shift_q;
  reg [W-1:0] out_word_q;

  wire sclk_rise;
  wire sclk_fall;
  wire rfs_fall;
  wire rfs_low;
  wire tfs_low;
  wire sel_high;
  wire short_word;
  wire cal_sel;
  wire [CW-1:0] rd_last;
  wire fifo_valid;
  wire [W-1:0] fifo_data;
  wire fifo_pop;
  wire [W-1:0] wr_word;

  function edge_up;
    input now_v;
    input old_v;
    begin
      edge_up = now_v & ~old_v;
    end
  endfunction

  assign sclk_rise = edge_up(pin_q[`ADC_PIN_SCLK], prev_q[`ADC_PIN_SCLK]);
  assign sclk_fall = edge_up(prev_q[`ADC_PIN_SCLK], pin_q[`ADC_PIN_SCLK]);
  assign rfs_fall = edge_up(prev_q[`ADC_PIN_RFS], pin_q[`ADC_PIN_RFS]);
  assign rfs_low = ~pin_q[`ADC_PIN_RFS];
  assign tfs_low = ~pin_q[`ADC_PIN_TFS];
  assign sel_high = pin_q[`ADC_PIN_SEL];
  assign short_word = ctrl_q[`ADC_CTRL_SHORT_BIT];
  assign cal_sel = ctrl_q[`ADC_CTRL_CALSEL_BIT];
  assign rd_last = (rd_kind_q == KIND_OUT && short_word) ?
                   LAST_SHORT : LAST_LONG;
  // first bit in ends up as msb
  assign wr_word = {wr_shift_q[W-2:0], pin_q[`ADC_PIN_SDI]};
  // refill only while no word is pending or being read
  assign fifo_pop = word_available_n & fifo_valid &
                    ~(rd_act_q & rd_kind_q == KIND_OUT);

  sample_fifo #(
    .WIDTH(W),
    .DEPTH(FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .core_clk(core_clk),
    .resetn(resetn),
    .in_data(sample_data),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  // pins are asynchronous; a change counts once stages 2 and 3 agree
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= `ADC_PIN_IDLE;
      s2_q <= `ADC_PIN_IDLE;
      s3_q <= `ADC_PIN_IDLE;
      pin_q <= `ADC_PIN_IDLE;
      prev_q <= `ADC_PIN_IDLE;
    end else begin
      s1_q <= {serial_clk, receive_frame_n, transmit_frame_n,
               register_select, serial_io_line_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
      // hold on disagreement so a settling bit never counts
      pin_q <= (s3_q & ~(s2_q ^ s3_q)) | (pin_q & (s2_q ^ s3_q));
      prev_q <= pin_q;
    end
  end

  always @* begin
    rd_act_d = rd_act_q;
    rd_kind_d = rd_kind_q;
    rd_cnt_d = rd_cnt_q;
    rd_shift_d = rd_shift_q;
    word_available_n_n_d = word_available_n;
    if (fifo_pop)
      word_available_n_n_d = 1'b0;
    if (rfs_fall && !rd_act_q) begin
      // select low reads control, high reads output or cal
      // select held high by the frame can never reach control
      if (!sel_high) begin
        rd_act_d = 1'b1;
        rd_kind_d = KIND_CTRL;
        rd_shift_d = ctrl_q;
      end else if (cal_sel) begin
        rd_act_d = 1'b1;
        rd_kind_d = KIND_CAL;
        rd_shift_d = cal_q;
      end else if (!word_available_n) begin
        // word pending: the output word is loaded and shifted out
        rd_act_d = 1'b1;
        rd_kind_d = KIND_OUT;
        rd_shift_d = out_word_q;
      end
      rd_cnt_d = {CW{1'b0}};
    end else if (sclk_fall && rd_act_q && rfs_low) begin
      // bit position survives frame gaps mid-word
      if (rd_cnt_q == rd_last) begin
        rd_act_d = 1'b0;
        rd_cnt_d = {CW{1'b0}};
        // final falling edge releases data ready
        if (rd_kind_q == KIND_OUT)
          word_available_n_n_d = 1'b1;
      end else begin
        // shift left so msb leaves first
        rd_shift_d = {rd_shift_q[W-2:0], 1'b0};
        rd_cnt_d = rd_cnt_q + CNT_ONE;
      end
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_act_q <= 1'b0;
      rd_kind_q <= KIND_OUT;
      rd_cnt_q <= {CW{1'b0}};
      rd_shift_q <= `ADC_OUT_RESET;
      word_available_n <= 1'b1;
      out_word_q <= `ADC_OUT_RESET;
      serial_io_line_out <= 1'b0;
      serial_io_line_oe <= 1'b0;
    end else begin
      rd_act_q <= rd_act_d;
      rd_kind_q <= rd_kind_d;
      rd_cnt_q <= rd_cnt_d;
      rd_shift_q <= rd_shift_d;
      word_available_n <= word_available_n_n_d;
      if (fifo_pop)
        out_word_q <= fifo_data;
      // pin carries the top of the shifter
      serial_io_line_out <= rd_shift_d[W-1];
      // drive only inside an open frame of a live read
      serial_io_line_oe <= rd_act_d & rfs_low & ~rfs_fall | rd_act_d &
                           rfs_fall;
    end
  end

  // writes: sampled on the high level, i.e. at each rising edge
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_cnt_q <= {CW{1'b0}};
      wr_shift_q <= `ADC_CTRL_RESET;
      ctrl_q <= `ADC_CTRL_RESET;
      cal_q <= `ADC_CAL_RESET;
      write_done <= 1'b0;
    end else begin
      write_done <= 1'b0;
      if (sclk_rise && tfs_low) begin
        // count runs on across frame gaps until all 24 bits
        if (wr_cnt_q == LAST_LONG) begin
          wr_cnt_q <= {CW{1'b0}};
          write_done <= 1'b1;
          // select low during the write picks control
          if (sel_high)
            cal_q <= wr_word;
          else
            ctrl_q <= wr_word;
        end else begin
          wr_cnt_q <= wr_cnt_q + CNT_ONE;
        end
        wr_shift_q <= wr_word;
      end
    end
  end
endmodule

// >>> verification/adc_serial_port_props.sv
`timescale 1ns/1ps
`include "adc_port_defines.vh"
module adc_serial_port_props (
  input wire core_clk, // clock
  input wire resetn, // reset, active low
  input wire receive_frame_n, // read frame
  input wire transmit_frame_n, // write frame
  input wire serial_io_line_oe, // data drive
  input wire word_available_n, // word pending
  input wire sample_valid, // sample offered
  input wire sample_ready, // fifo room
  input wire [`ADC_WORD_BITS-1:0] ctrl_q, // control
  input wire [`ADC_WORD_BITS-1:0] cal_q, // calibration
  input wire write_done // write pulse
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_oe_off;
    $rose(receive_frame_n) |-> ##[1:8] !serial_io_line_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("oe held");
  property p_oe_frame;
    $rose(serial_io_line_oe) |-> !receive_frame_n;
  endproperty
  a_oe_frame: assert property (p_oe_frame) else $error("oe early");
  property p_wr_quiet;
    (!transmit_frame_n && receive_frame_n) [*8] |-> !serial_io_line_oe;
  endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("oe on write");
  property p_dav_rise;
    $rose(word_available_n) |-> $past(serial_io_line_oe);
  endproperty
  a_dav_rise: assert property (p_dav_rise) else $error("dav rise");
  property p_dav_idle;
    receive_frame_n [*8] |-> !$rose(word_available_n);
  endproperty
  a_dav_idle: assert property (p_dav_idle) else $error("dav idle");
  property p_ctrl_chg;
    $changed(ctrl_q) |-> ##[0:1] write_done;
  endproperty
  a_ctrl_chg: assert property (p_ctrl_chg) else $error("ctrl chg");
  property p_cal_chg;
    $changed(cal_q) |-> ##[0:1] write_done;
  endproperty
  a_cal_chg: assert property (p_cal_chg) else $error("cal chg");
  property p_fill;
    sample_valid && sample_ready && word_available_n && receive_frame_n
      |-> ##[1:4] !word_available_n;
  endproperty
  a_fill: assert property (p_fill) else $error("no word");
  c_wd: cover property (write_done);
  c_rd: cover property ($rose(word_available_n));
  c_full: cover property ($fell(sample_ready));
endmodule

// >>> verification/serial_host_model.sv
`timescale 1ns/1ps
module serial_host_model (
  input wire core_clk, // pacing clock
  input wire line_v, // data wire level
  output logic serial_clk, // serial clock
  output logic receive_frame_n, // read frame
  output logic transmit_frame_n, // write frame
  output logic register_select, // select
  output logic drv, // host data
  output logic drv_en // host drives wire
);
  initial begin
    serial_clk = 1'b0;
    receive_frame_n = 1'b1;
    transmit_frame_n = 1'b1;
    register_select = 1'b1;
    drv = 1'b0;
    drv_en = 1'b0;
  end
  task automatic step(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic xfer(input logic rd, input logic s, input int n,
      input logic [23:0] w, output logic [23:0] r);
    r = 24'h000000;
    register_select = s;
    step(2);
    // never both frames low at once
    if (rd) receive_frame_n = 1'b0;
    else transmit_frame_n = 1'b0;
    drv_en = !rd;
    step(8);
    for (int i = 0; i < n; i++) begin
      step(2);
      drv = w[23-i];
      step(2);
      serial_clk = 1'b1;
      step(4);
      r = {r[22:0], line_v};
      serial_clk = 1'b0;
    end
    step(4);
    receive_frame_n = 1'b1;
    transmit_frame_n = 1'b1;
    drv_en = 1'b0;
    step(2);
    register_select = 1'b1;
    step(8);
  endtask
endmodule

// >>> verification/adc_serial_port_tb.sv
`timescale 1ns/1ps
module adc_serial_port_tb;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [23:0] sample_data = 24'h000000;
  logic sample_valid = 1'b0;
  logic flip_q = 1'b0;
  wire serial_clk, receive_frame_n, transmit_frame_n, register_select;
  wire drv, drv_en, line_v, line_out, line_oe, dav_n, s_ready, wdone;
  wire [23:0] ctrl_v, cal_v;
  int fail_count = 0;
  int n_compared = 0;
  int dav_rises = 0;
  int n_wdone = 0;
  int n_oe = 0;
  logic dav_q = 1'b1;
  always #12.5 core_clk = ~core_clk;
  // released wire toggles so stale bits never match
  always @(posedge core_clk) flip_q <= ~flip_q;
  // short pulses are counted where outputs are settled
  always @(negedge core_clk) begin
    dav_q <= dav_n;
    if (dav_n === 1'b1 && dav_q === 1'b0) dav_rises <= dav_rises + 1;
    if (wdone === 1'b1) n_wdone <= n_wdone + 1;
    if (line_oe === 1'b1) n_oe <= n_oe + 1;
  end
  assign line_v = line_oe ? line_out : (drv_en ? drv : flip_q);
  serial_host_model u_host (.core_clk(core_clk), .line_v(line_v),
    .serial_clk(serial_clk), .receive_frame_n(receive_frame_n),
    .transmit_frame_n(transmit_frame_n),
    .register_select(register_select), .drv(drv), .drv_en(drv_en));
  adc_serial_port u_dut (.core_clk(core_clk), .resetn(resetn),
    .serial_clk(serial_clk), .receive_frame_n(receive_frame_n),
    .transmit_frame_n(transmit_frame_n),
    .register_select(register_select), .serial_io_line_in(line_v),
    .serial_io_line_out(line_out), .serial_io_line_oe(line_oe),
    .word_available_n(dav_n), .sample_data(sample_data),
    .sample_valid(sample_valid), .sample_ready(s_ready),
    .ctrl_q(ctrl_v), .cal_q(cal_v), .write_done(wdone));
  task automatic check(input string what, input logic [23:0] e,
      input logic [23:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr24(input logic s, input logic [23:0] v);
    logic [23:0] r;
    for (int k = 0; k < 3; k++) u_host.xfer(1'b0, s, 8, v << (8*k), r);
  endtask
  task automatic rd(input logic s, input int nb, output logic [23:0] v);
    logic [23:0] r;
    v = 24'h000000;
    for (int k = 0; k < nb; k++) begin
      if (s) check("dav", 24'h000000, {23'h0, dav_n});
      u_host.xfer(1'b1, s, 8, 24'h000000, r);
      v = {v[15:0], r[7:0]};
    end
  endtask
  task automatic push(input logic [23:0] v, output logic ok);
    ok = 1'b0;
    @(negedge core_clk);
    sample_data = v;
    sample_valid = 1'b1;
    for (int k = 0; k < 6 && !ok; k++) begin
      ok = (s_ready === 1'b1);
      @(posedge core_clk);
      if (!ok) @(negedge core_clk);
    end
    @(negedge core_clk);
    sample_valid = 1'b0;
  endtask
  task automatic wait_dav;
    for (int k = 0; k < 40 && dav_n !== 1'b0; k++) @(negedge core_clk);
  endtask
  task automatic t_ctrl;
    logic [23:0] v;
    int w0;
    w0 = n_wdone;
    wr24(1'b0, 24'hC35A00);
    check("write pulses", 24'h000001, n_wdone - w0);
    check("ctrl", 24'hC35A00, ctrl_v);
    rd(1'b0, 3, v);
    check("ctrl read", 24'hC35A00, v);
    $display("test ctrl done");
  endtask
  task automatic t_cal;
    logic [23:0] v;
    logic ok;
    int o0;
    wr24(1'b1, 24'h3C96A5);
    check("cal", 24'h3C96A5, cal_v);
    check("ctrl kept", 24'hC35A00, ctrl_v);
    wr24(1'b0, 24'h000002);
    rd(1'b0, 0, v);
    u_host.xfer(1'b1, 1'b1, 24, 24'h000000, v);
    check("cal read", 24'h3C96A5, v);
    wr24(1'b0, 24'h000001);
    o0 = n_oe;
    u_host.xfer(1'b1, 1'b1, 8, 24'h000000, v);
    check("refused read oe", 24'h000000, n_oe - o0);
    push(24'hBEEF12, ok);
    wait_dav;
    rd(1'b1, 2, v);
    check("short word", 24'h00BEEF, v);
    check("dav end", 24'h000001, {23'h0, dav_n});
    wr24(1'b0, 24'h000000);
    $display("test cal done");
  endtask
  task automatic t_fifo;
    logic [23:0] v;
    logic ok;
    int n;
    int r0;
    n = 0;
    for (int i = 0; i < 10; i++) begin
      push(24'h100000 + i, ok);
      n += ok;
    end
    check("accepted", 24'h000009, n[23:0]);
    for (int i = 0; i < 9; i++) begin
      wait_dav;
      r0 = dav_rises;
      rd(1'b1, 3, v);
      check("word", 24'h100000 + i, v);
      check("dav rises", 24'h000001, dav_rises - r0);
    end
    check("ready", 24'h000001, {23'h0, s_ready});
    $display("test fifo done");
  endtask
  initial begin
    repeat (12) @(negedge core_clk);
    check("reset oe", 24'h000000, {23'h0, line_oe});
    check("reset dav", 24'h000001, {23'h0, dav_n});
    resetn = 1'b1;
    repeat (8) @(negedge core_clk);
    t_ctrl;
    t_cal;
    t_fifo;
    wrap_up;
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    fail_count++;
    $display("watchdog expired");
    wrap_up;
  end
endmodule
bind adc_serial_port adc_serial_port_props u_props (.core_clk(core_clk),
  .resetn(resetn), .receive_frame_n(receive_frame_n),
  .transmit_frame_n(transmit_frame_n),
  .serial_io_line_oe(serial_io_line_oe),
  .word_available_n(word_available_n), .sample_valid(sample_valid),
  .sample_ready(sample_ready), .ctrl_q(ctrl_q), .cal_q(cal_q),
  .write_done(write_done));
